// >>> opd_map.svh
// Register offsets, field positions, reset values and timing defaults of the protection block
`ifndef OPD_MAP_SVH
`define OPD_MAP_SVH
`define OPD_ADDR_OUT_CTL 8'h11
`define OPD_ADDR_CFG_ONE 8'h12
`define OPD_ADDR_GLOBAL 8'h71
`define OPD_ADDR_CFG_TWO 8'hA2
`define OPD_DIAG_BASE 8'h31
`define OPD_DIAG_STEP 8'h10
`define OPD_RST_OUT_CTL 8'hF0
`define OPD_RST_CFG 8'h00
`define OPD_BIT_OVERVOLT_LOCKOUT 0
`define OPD_BIT_COR 0
`define OPD_DIAG_STATUS 5
`define OPD_DIAG_TW 4
`define OPD_DIAG_TSD 3
`define OPD_DIAG_STB 2
`define OPD_DIAG_OL 1
`define OPD_GLB_FAULT 7
`define OPD_CNT_W 16
`define OPD_BLANK_CYC 16'h0100
`define OPD_FAULT_CYC 16'h0040
`define OPD_RECOV_CYC 16'h0040
`define OPD_OL_CYC 16'h0200
`endif

// >>> opd_pkg.sv
// Types shared by the protection and diagnostic supervisor
package opd_pkg;
  // Short-to-battery sequencer states per channel
  typedef enum logic [2:0] {S_OFF, S_BLANK, S_RUN, S_FILT, S_SHORT, S_RECOV} opd_stb_type;
endpackage : opd_pkg

// >>> opd_output_protection_diag.sv
// Four-channel protection and diagnostic supervisor with its register file
`timescale 1ns/1ns
`include "opd_map.svh"
module opd_output_protection_diag #(
  parameter logic [`OPD_CNT_W-1:0] BLANK_CYC = `OPD_BLANK_CYC,
  parameter logic [`OPD_CNT_W-1:0] FAULT_CYC = `OPD_FAULT_CYC,
  parameter logic [`OPD_CNT_W-1:0] RECOV_CYC = `OPD_RECOV_CYC,
  parameter logic [`OPD_CNT_W-1:0] OL_CYC = `OPD_OL_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] supply_under,
  input wire logic [1:0] supply_over,
  input wire logic [3:0] therm_warn,
  input wire logic [3:0] therm_shut,
  input wire logic [3:0] short_cmp,
  input wire logic open_load_cmp,
  output logic [3:0] gate_on,
  output logic [3:0] rev_block,
  output logic [3:0] open_load_src
);

  // Whole state of the block
  typedef struct packed {
    logic [16:0] sync1; // First synchroniser stage
    logic [16:0] sync2; // Second synchroniser stage
    logic [7:0] out_ctl; // Enables low nibble, blanking high nibble
    logic [7:0] cfg_one; // Lockout configuration
    logic [7:0] cfg_two; // Clear mode and open-load select
    logic [1:0] under_f; // Supply undervoltage flags
    logic [1:0] over_f; // Supply overvoltage flags
    logic [3:0] tw_f; // Thermal warning flags
    logic [3:0] tsd_f; // Thermal shutdown flags, also the latch
    logic [3:0] stb_f; // Battery short flags
    logic [3:0] ol_f; // Open-load flags
    opd_pkg::opd_stb_type [3:0] seq; // Short sequencers
    logic [3:0][`OPD_CNT_W-1:0] cnt; // Sequencer timers
    logic [`OPD_CNT_W-1:0] ol_cnt; // Open-load filter timer
    logic ol_det; // Open-load confirmed
    logic [3:0] gate; // Registered channel gating
    logic [3:0] rblk; // Registered reverse blocking
    logic [3:0] ol_src; // Registered detector routing
    logic [7:0] rdata; // Registered read data
  } opd_state_type;

  opd_state_type st; // Current state
  opd_state_type next_st; // Next state

  // Synchronised comparator views
  logic [1:0] uv_s;
  logic [1:0] ov_s;
  logic [3:0] tw_s;
  logic [3:0] tsd_s;
  logic [3:0] sc_s;
  logic olc_s;
  assign uv_s = st.sync2[1:0];
  assign ov_s = st.sync2[3:2];
  assign tw_s = st.sync2[7:4];
  assign tsd_s = st.sync2[11:8];
  assign sc_s = st.sync2[15:12];
  assign olc_s = st.sync2[16];

  logic clear_on_read_mode; // Clear-on-read mode
  logic overvolt_lockout; // Overvoltage lockout
  logic [2:0] ol_sel; // Open-load channel select, zero is none
  assign clear_on_read_mode = st.cfg_two[`OPD_BIT_COR];
  assign overvolt_lockout = st.cfg_one[`OPD_BIT_OVERVOLT_LOCKOUT];
  assign ol_sel = st.cfg_two[3:1];

  // Per-channel derived terms
  logic [3:0] ch_uv; // Undervoltage of the feeding supply
  logic [3:0] ch_ov; // Overvoltage of the feeding supply
  logic [3:0] want; // Channel allowed and requested on
  logic [3:0] ol_one; // Detector routed to this channel
  logic [3:0] sc_eff; // Short seen with reporting allowed
  logic [3:0] wr_hit; // Diagnostic register written
  logic [3:0] rd_clr; // Diagnostic register read in retain mode
  logic [3:0][7:0] diag; // Diagnostic register images

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_ch
      localparam logic [7:0] DIAG_ADDR = 8'(`OPD_DIAG_BASE + `OPD_DIAG_STEP * g);
      // Pair mapping onto the two supplies
      assign ch_uv[g] = uv_s[g / 2];
      assign ch_ov[g] = ov_s[g / 2];
      // Undervoltage, lockout and shutdown latch gate the enable bit
      assign want[g] = st.out_ctl[g] & ~st.tsd_f[g] & ~ch_uv[g] & ~(overvolt_lockout & ch_ov[g]);
      assign ol_one[g] = (ol_sel == 3'(g + 1));
      // Short reporting muted under undervoltage or open-load selection
      assign sc_eff[g] = sc_s[g] & ~ch_uv[g] & ~ol_one[g];
      assign wr_hit[g] = reg_wr & (reg_addr == DIAG_ADDR);
      assign rd_clr[g] = reg_rd & clear_on_read_mode & (reg_addr == DIAG_ADDR);
      // Status mirrors real gating; lockout adds no other bit
      assign diag[g] = {2'h0, st.gate[g], st.tw_f[g], st.tsd_f[g], st.stb_f[g], st.ol_f[g], 1'b0};
    end
  endgenerate

  logic glb_fault; // Any short or open load flagged
  assign glb_fault = |(st.stb_f | st.ol_f);
  logic glb_rd; // Global register read in retain mode
  assign glb_rd = reg_rd & clear_on_read_mode & (reg_addr == `OPD_ADDR_GLOBAL);

  // Flag update: set wins, else auto clear or retain until cleared
  function automatic logic opd_flag(input logic f, input logic cond, input logic keep,
                                    input logic clr);
    logic r;
    r = f;
    if (cond)
    begin
      r = 1'b1;
    end
    else if (!keep || clr)
    begin
      r = 1'b0;
    end
    return r;
  endfunction : opd_flag

  // Next-state logic
  always_comb
  begin
    next_st = st;
    next_st.sync1 = {open_load_cmp, short_cmp, therm_shut, therm_warn, supply_over, supply_under};
    next_st.sync2 = st.sync1;
    // Register writes
    if (reg_wr)
    begin
      if (reg_addr == `OPD_ADDR_OUT_CTL)
      begin
        next_st.out_ctl = reg_wdata;
      end
      else if (reg_addr == `OPD_ADDR_CFG_ONE)
      begin
        next_st.cfg_one = reg_wdata;
      end
      else if (reg_addr == `OPD_ADDR_CFG_TWO)
      begin
        next_st.cfg_two = reg_wdata;
      end
    end
    // Supply flags
    for (int s = 0; s < 2; s++)
    begin
      next_st.under_f[s] = opd_flag(st.under_f[s], uv_s[s], clear_on_read_mode, glb_rd);
      next_st.over_f[s] = opd_flag(st.over_f[s], ov_s[s], clear_on_read_mode, glb_rd);
    end
    // Channel flags and short sequencers
    for (int i = 0; i < 4; i++)
    begin
      // Warning never touches gating
      next_st.tw_f[i] = opd_flag(st.tw_f[i], tw_s[i], clear_on_read_mode,
                                 rd_clr[i] | (wr_hit[i] & reg_wdata[`OPD_DIAG_TW]));
      // Shutdown latch is cleared only by the host
      next_st.tsd_f[i] = opd_flag(st.tsd_f[i], tsd_s[i], 1'b1,
                                  wr_hit[i] & reg_wdata[`OPD_DIAG_TSD]);
      next_st.stb_f[i] = opd_flag(st.stb_f[i], st.seq[i] == opd_pkg::S_SHORT, clear_on_read_mode,
                                  rd_clr[i] | (wr_hit[i] & reg_wdata[`OPD_DIAG_STB]));
      next_st.ol_f[i] = opd_flag(st.ol_f[i], st.ol_det & ol_one[i], clear_on_read_mode,
                                 rd_clr[i] | (wr_hit[i] & reg_wdata[`OPD_DIAG_OL]));
      next_st.cnt[i] = st.cnt[i] + 16'h0001;
      case (st.seq[i])
        opd_pkg::S_OFF:
        begin
          // Off-state short is also filtered and caught
          next_st.cnt[i] = '0;
          if (sc_eff[i])
          begin
            next_st.seq[i] = opd_pkg::S_FILT;
          end
          else if (want[i])
          begin
            next_st.seq[i] = st.out_ctl[4 + i] ? opd_pkg::S_BLANK : opd_pkg::S_RUN;
          end
        end
        opd_pkg::S_BLANK:
        begin
          // Turn-on blanking; a short at its end extends by the filter
          if (!want[i])
          begin
            next_st.seq[i] = opd_pkg::S_OFF;
          end
          else if (st.cnt[i] >= BLANK_CYC - 16'h0001)
          begin
            next_st.cnt[i] = '0;
            next_st.seq[i] = sc_eff[i] ? opd_pkg::S_FILT : opd_pkg::S_RUN;
          end
        end
        opd_pkg::S_RUN:
        begin
          // Normal on state
          next_st.cnt[i] = '0;
          if (!want[i])
          begin
            next_st.seq[i] = opd_pkg::S_OFF;
          end
          else if (sc_eff[i])
          begin
            next_st.seq[i] = opd_pkg::S_FILT;
          end
        end
        opd_pkg::S_FILT:
        begin
          // Short shorter than the filter leaves the channel alone
          if (!sc_eff[i])
          begin
            next_st.cnt[i] = '0;
            next_st.seq[i] = want[i] ? opd_pkg::S_RUN : opd_pkg::S_OFF;
          end
          else if (st.cnt[i] >= FAULT_CYC - 16'h0001)
          begin
            next_st.cnt[i] = '0;
            next_st.seq[i] = opd_pkg::S_SHORT;
          end
        end
        opd_pkg::S_SHORT:
        begin
          // Held off and blocked until the short goes; writes to the diagnostic register cannot release it
          next_st.cnt[i] = '0;
          if (!sc_eff[i])
          begin
            next_st.seq[i] = opd_pkg::S_RECOV;
          end
        end
        opd_pkg::S_RECOV:
        begin
          // Recovery filter, then follow the present enable bit
          if (sc_eff[i])
          begin
            next_st.cnt[i] = '0;
            next_st.seq[i] = opd_pkg::S_SHORT;
          end
          else if (st.cnt[i] >= RECOV_CYC - 16'h0001)
          begin
            next_st.cnt[i] = '0;
            if (!want[i])
            begin
              next_st.seq[i] = opd_pkg::S_OFF;
            end
            else
            begin
              next_st.seq[i] = st.out_ctl[4 + i] ? opd_pkg::S_BLANK : opd_pkg::S_RUN;
            end
          end
        end
        default:
        begin
          next_st.seq[i] = opd_pkg::S_OFF;
        end
      endcase
      // Gating only in on states and only while allowed
      next_st.gate[i] = want[i] & (next_st.seq[i] == opd_pkg::S_BLANK ||
                        next_st.seq[i] == opd_pkg::S_RUN ||
                        next_st.seq[i] == opd_pkg::S_FILT);
      next_st.rblk[i] = (next_st.seq[i] == opd_pkg::S_SHORT) ||
                        (next_st.seq[i] == opd_pkg::S_RECOV);
    end
    // Open-load detector, armed only while its channel is disabled
    next_st.ol_src = ol_one & ~st.out_ctl[3:0];
    if (!(|next_st.ol_src) || !olc_s)
    begin
      next_st.ol_cnt = '0;
      next_st.ol_det = 1'b0;
    end
    else if (st.ol_cnt >= OL_CYC - 16'h0001)
    begin
      next_st.ol_det = |st.ol_src;
    end
    else
    begin
      next_st.ol_cnt = st.ol_cnt + 16'h0001;
    end
    // Read data
    next_st.rdata = 8'h00;
    if (reg_rd)
    begin
      if (reg_addr == `OPD_ADDR_OUT_CTL)
      begin
        next_st.rdata = st.out_ctl;
      end
      else if (reg_addr == `OPD_ADDR_CFG_ONE)
      begin
        next_st.rdata = st.cfg_one;
      end
      else if (reg_addr == `OPD_ADDR_GLOBAL)
      begin
        next_st.rdata = {glb_fault, 3'h0, st.over_f, st.under_f};
      end
      else if (reg_addr == `OPD_ADDR_CFG_TWO)
      begin
        next_st.rdata = st.cfg_two;
      end
      for (int k = 0; k < 4; k++)
      begin
        if (reg_addr == 8'(`OPD_DIAG_BASE + `OPD_DIAG_STEP * k))
        begin
          next_st.rdata = diag[k];
        end
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.out_ctl <= `OPD_RST_OUT_CTL;
      st.cfg_one <= `OPD_RST_CFG;
      st.cfg_two <= `OPD_RST_CFG;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = st.rdata;
  assign gate_on = st.gate;
  assign rev_block = st.rblk;
  assign open_load_src = st.ol_src;

  // Undervoltage pair forced off
  chk_uv_pair_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    uv_s[0] |=> !gate_on[0] && !gate_on[1])
    else $error("undervoltage did not force pair off");
  // Supply two maps to channels three and four
  chk_pair_map: assert property (@(posedge sys_clk) disable iff (sys_rst)
    uv_s[1] |=> !gate_on[2] && !gate_on[3] && st.under_f[1])
    else $error("supply two mapping wrong");
  // Lockout disables on overvoltage
  chk_overvolt_lockout_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    overvolt_lockout && ov_s[1] |=> !gate_on[3] && st.over_f[1])
    else $error("lockout did not disable channel");
  // Auto clear of supply flag
  chk_supply_auto: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !clear_on_read_mode && !uv_s[0] |=> !st.under_f[0])
    else $error("supply flag not auto cleared");
  // Retained supply flag survives without a read
  chk_supply_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clear_on_read_mode && st.under_f[1] && !reg_rd |=> st.under_f[1])
    else $error("retained supply flag lost");
  // Warning sets flag
  chk_warn_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tw_s[0] |=> st.tw_f[0])
    else $error("warning flag not set");
  // Shutdown latch holds the channel off
  chk_tsd_latch: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tsd_s[2] |=> st.tsd_f[2] ##1 !gate_on[2])
    else $error("shutdown did not latch off");
  // Latch survives until cleared by a write
  chk_tsd_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st.tsd_f[2] && !wr_hit[2] |=> st.tsd_f[2] && !gate_on[2])
    else $error("shutdown latch released without clear");
  // Confirmed short keeps channel off and blocked
  chk_short_block: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st.seq[0] == opd_pkg::S_SHORT |=> !gate_on[0] && rev_block[0] && st.stb_f[0])
    else $error("short not blocked");
  // Fault filter expiry confirms the short
  chk_filter_end: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st.seq[3] == opd_pkg::S_FILT && sc_eff[3] && st.cnt[3] == FAULT_CYC - 16'h0001
    |=> st.seq[3] == opd_pkg::S_SHORT)
    else $error("fault filter did not confirm short");
  // Open-load confirmation needs a held comparator
  chk_ol_filter: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(st.ol_det) |-> $past(olc_s) && $past(st.ol_cnt) == OL_CYC - 16'h0001)
    else $error("open load confirmed without filter");
  // Global fault follows channel short flag
  chk_glb_fault: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st.stb_f[3] && reg_rd && reg_addr == `OPD_ADDR_GLOBAL |=> reg_rdata[`OPD_GLB_FAULT])
    else $error("global fault missing");
  cov_short: cover property (@(posedge sys_clk) disable iff (sys_rst)
    st.seq[0] == opd_pkg::S_SHORT);
  cov_recover: cover property (@(posedge sys_clk) disable iff (sys_rst)
    st.seq[0] == opd_pkg::S_RECOV ##1 st.seq[0] == opd_pkg::S_BLANK);
  cov_open_load: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(st.ol_det));
  cov_tsd: cover property (@(posedge sys_clk) disable iff (sys_rst) $fell(st.tsd_f[2]));

endmodule : opd_output_protection_diag

// >>> opd_host_model.sv
// Host model that drives the register strobes of the protection block
`timescale 1ns/1ns
module opd_host_model (
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // Idle bus from time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write strobe; released lines are scrambled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  // One-cycle read strobe; data taken the cycle after
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd
endmodule : opd_host_model

// >>> tb_output_protection_diag.sv
// Self-checking bench for the protection and diagnostic supervisor
`timescale 1ns/1ns
`include "opd_map.svh"
module tb_output_protection_diag;
  localparam logic [15:0] N = 16'h0004; // Shortened timer counts
  logic sys_clk;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [1:0] supply_under;
  logic [1:0] supply_over;
  logic [3:0] therm_warn;
  logic [3:0] therm_shut;
  logic [3:0] short_cmp;
  logic open_load_cmp;
  logic [3:0] gate_on;
  logic [3:0] rev_block;
  logic [3:0] open_load_src;
  int n_errors = 0; // Mismatches
  int checks_done = 0; // Comparisons
  int cycles = 0; // Hang guard
  // Device under test
  opd_output_protection_diag #(.BLANK_CYC(N), .FAULT_CYC(N), .RECOV_CYC(N), .OL_CYC(N)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .supply_under(supply_under),
    .supply_over(supply_over), .therm_warn(therm_warn), .therm_shut(therm_shut),
    .short_cmp(short_cmp), .open_load_cmp(open_load_cmp), .gate_on(gate_on),
    .rev_block(rev_block), .open_load_src(open_load_src));
  // Host on the register side
  opd_host_model host_u (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // Free-running clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Verdict and end of run
  task automatic conclude;
    $display("Checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  // Cut a hang short
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      conclude();
    end
  end
  // One comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Read a register and compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host_u.rd(a, v);
    chk(v, exp);
  endtask : rchk
  // Let falling edges pass
  task automatic wn(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wn
  // Diagnostic register address of a channel
  function automatic logic [7:0] da(input int i);
    return `OPD_DIAG_BASE + `OPD_DIAG_STEP * 8'(i);
  endfunction : da
  // Reset values, read-only and unmapped places
  task automatic t_reset;
    chk({4'h0, gate_on}, 8'h00);
    rchk(`OPD_ADDR_OUT_CTL, 8'hF0);
    rchk(`OPD_ADDR_CFG_ONE, 8'h00);
    rchk(`OPD_ADDR_CFG_TWO, 8'h00);
    host_u.wr(`OPD_ADDR_GLOBAL, 8'hFF);
    rchk(`OPD_ADDR_GLOBAL, 8'h00);
    rchk(8'h20, 8'h00);
  endtask : t_reset
  // Supply under and over handling per pair
  task automatic t_supply;
    host_u.wr(`OPD_ADDR_OUT_CTL, 8'hFF);
    wn(20);
    chk({4'h0, gate_on}, 8'h0F);
    supply_under = 2'b01;
    wn(8);
    chk({4'h0, gate_on}, 8'h0C);
    rchk(`OPD_ADDR_GLOBAL, 8'h01);
    supply_under = 2'b00;
    wn(20);
    chk({4'h0, gate_on}, 8'h0F);
    rchk(`OPD_ADDR_GLOBAL, 8'h00);
    supply_over = 2'b10;
    wn(8);
    chk({4'h0, gate_on}, 8'h0F);
    rchk(`OPD_ADDR_GLOBAL, 8'h08);
    host_u.wr(`OPD_ADDR_CFG_ONE, 8'h01);
    wn(8);
    chk({4'h0, gate_on}, 8'h03);
    rchk(da(2), 8'h00);
    supply_over = 2'b00;
    wn(20);
    chk({4'h0, gate_on}, 8'h0F);
    host_u.wr(`OPD_ADDR_CFG_ONE, 8'h00);
    host_u.wr(`OPD_ADDR_CFG_TWO, 8'h01);
    supply_under = 2'b10;
    wn(8);
    supply_under = 2'b00;
    wn(20);
    rchk(`OPD_ADDR_GLOBAL, 8'h02);
    rchk(`OPD_ADDR_GLOBAL, 8'h00);
    host_u.wr(`OPD_ADDR_CFG_TWO, 8'h00);
  endtask : t_supply
  // Thermal warning in both clearing modes
  task automatic t_warn;
    therm_warn = 4'h1;
    wn(8);
    chk({4'h0, gate_on}, 8'h0F);
    rchk(da(0), 8'h30);
    therm_warn = 4'h0;
    wn(8);
    rchk(da(0), 8'h20);
    host_u.wr(`OPD_ADDR_CFG_TWO, 8'h01);
    therm_warn = 4'h2;
    wn(8);
    therm_warn = 4'h0;
    wn(8);
    rchk(da(1), 8'h30);
    rchk(da(1), 8'h20);
    host_u.wr(`OPD_ADDR_CFG_TWO, 8'h00);
  endtask : t_warn
  // Thermal shutdown latch and host clear
  task automatic t_shut;
    therm_shut = 4'h4;
    wn(8);
    chk({4'h0, gate_on}, 8'h0B);
    therm_shut = 4'h0;
    wn(20);
    chk({4'h0, gate_on}, 8'h0B);
    rchk(da(2), 8'h08);
    host_u.wr(da(2), 8'h08);
    wn(20);
    chk({4'h0, gate_on}, 8'h0F);
  endtask : t_shut
  // Battery short on and off, filters, refusal, muting
  task automatic t_short;
    short_cmp = 4'h8;
    wn(1);
    short_cmp = 4'h0;
    wn(12);
    chk({4'h0, gate_on}, 8'h0F);
    short_cmp = 4'h8;
    wn(12);
    chk({4'h0, gate_on}, 8'h07);
    chk({4'h0, rev_block}, 8'h08);
    rchk(da(3), 8'h04);
    rchk(`OPD_ADDR_GLOBAL, 8'h80);
    host_u.wr(da(3), 8'h04);
    wn(8);
    chk({4'h0, gate_on}, 8'h07);
    short_cmp = 4'h0;
    wn(20);
    chk({4'h0, gate_on}, 8'h0F);
    chk({4'h0, rev_block}, 8'h00);
    rchk(da(3), 8'h20);
    host_u.wr(`OPD_ADDR_OUT_CTL, 8'hFE);
    short_cmp = 4'h1;
    wn(12);
    chk({4'h0, rev_block}, 8'h01);
    host_u.wr(`OPD_ADDR_OUT_CTL, 8'hFF);
    wn(12);
    chk({4'h0, gate_on}, 8'h0E);
    short_cmp = 4'h0;
    wn(20);
    chk({4'h0, gate_on}, 8'h0F);
    supply_under = 2'b10;
    short_cmp = 4'h8;
    wn(12);
    rchk(da(3), 8'h00);
    rchk(`OPD_ADDR_GLOBAL, 8'h02);
    short_cmp = 4'h0;
    supply_under = 2'b00;
    wn(20);
    // Blanking off on channel four: a short right after turn-on is filtered at once
    host_u.wr(`OPD_ADDR_OUT_CTL, 8'h77);
    wn(4);
    host_u.wr(`OPD_ADDR_OUT_CTL, 8'h7F);
    short_cmp = 4'h8;
    wn(8);
    chk({4'h0, gate_on}, 8'h07);
    short_cmp = 4'h0;
    wn(20);
    chk({4'h0, gate_on}, 8'h0F);
  endtask : t_short
  // Off-state open load on a selected channel
  task automatic t_open;
    host_u.wr(`OPD_ADDR_CFG_TWO, 8'h06);
    host_u.wr(`OPD_ADDR_OUT_CTL, 8'hFB);
    wn(8);
    chk({4'h0, open_load_src}, 8'h04);
    open_load_cmp = 1'b1;
    wn(1);
    open_load_cmp = 1'b0;
    wn(12);
    rchk(da(2), 8'h00);
    open_load_cmp = 1'b1;
    wn(12);
    rchk(da(2), 8'h02);
    rchk(`OPD_ADDR_GLOBAL, 8'h80);
    short_cmp = 4'h4;
    wn(12);
    rchk(da(2), 8'h02);
    short_cmp = 4'h0;
    open_load_cmp = 1'b0;
    wn(20);
    rchk(da(2), 8'h00);
    host_u.wr(`OPD_ADDR_OUT_CTL, 8'hFF);
    wn(8);
    chk({4'h0, open_load_src}, 8'h00);
    host_u.wr(`OPD_ADDR_OUT_CTL, 8'hFB);
    wn(8);
    chk({4'h0, open_load_src}, 8'h04);
  endtask : t_open
  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    supply_under = 2'b00;
    supply_over = 2'b00;
    therm_warn = 4'h0;
    therm_shut = 4'h0;
    short_cmp = 4'h0;
    open_load_cmp = 1'b0;
    wn(12);
    sys_rst = 1'b0;
    t_reset();
    t_supply();
    t_warn();
    t_shut();
    t_short();
    t_open();
    conclude();
  end
endmodule : tb_output_protection_diag
